// [design/fpet_pkg.sv]
// Package for the flash program/erase timing sequencer
package fpet_pkg;
  // Timing-generator periods per operation phase
  localparam int unsigned WORD_TICKS = 30;
  localparam int unsigned BLK_FIRST_TICKS = 25;
  localparam int unsigned BLK_NEXT_TICKS = 18;
  localparam int unsigned BLK_END_TICKS = 6;
  localparam int unsigned MASS_ERASE_TICKS = 10593;
  localparam int unsigned SEG_ERASE_TICKS = 4819;
  // Items in one block
  localparam int unsigned BLOCK_ITEMS = 64;
  // Timebase limits in kHz, kept by software
  localparam int unsigned TIMEBASE_FREQ_MIN_KHZ = 257;
  localparam int unsigned TIMEBASE_FREQ_MAX_KHZ = 476;
  // Counter width
  localparam int unsigned CNT_W = 14;

  // Operation codes
  typedef enum logic [1:0] {
    FPET_OP_WORD = 2'h0,
    FPET_OP_BLOCK = 2'h1,
    FPET_OP_SEG = 2'h2,
    FPET_OP_MASS = 2'h3
  } fpet_op_e;

  // Sequencer states, Gray along idle-run-blkwait-end
  typedef enum logic [1:0] {
    FPET_IDLE = 2'h0,
    FPET_RUN = 2'h1,
    FPET_BWAIT = 2'h3,
    FPET_BEND = 2'h2
  } fpet_state_e;

  // Request bundle
  typedef struct packed {
    logic start;
    fpet_op_e op;
  } fpet_req_s;

  // Status bundle
  typedef struct packed {
    logic busy;
    logic done;
    logic item_pulse;
  } fpet_stat_s;
endpackage

// [design/fpet_seq.sv]
// Flash program/erase timing sequencer
`timescale 1ns/100ps
// Behaviour
// - Word program lasts 30 timebase periods
// - Block first item takes 25 periods
// - Block following items take 18 periods
// - Block end wait of 6 periods
// - Mass erase 10593, segment 4819 periods
module fpet_seq
  import fpet_pkg::*;
#(
  parameter int unsigned MASS_TICKS = MASS_ERASE_TICKS,
  parameter int unsigned SEG_TICKS = SEG_ERASE_TICKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Timebase tick, one clk per timebase period
  input wire logic tick,
  // Command side
  input wire fpet_req_s req,
  input wire logic blk_next,
  input wire logic blk_last,
  // Status and flash array side
  output fpet_stat_s stat,
  output logic array_pgm_en,
  output logic array_erase_en
);

  // State, counter, operation
  fpet_state_e state_ff;
  fpet_state_e nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  fpet_op_e op_ff;
  fpet_op_e nxt_op;
  logic done_ff;
  logic nxt_done;
  logic item_ff;
  logic nxt_item;

  // Period count for a new operation
  function automatic logic [CNT_W-1:0] op_ticks(input fpet_op_e op);
    case (op)
      FPET_OP_WORD: op_ticks = CNT_W'(WORD_TICKS);
      FPET_OP_BLOCK: op_ticks = CNT_W'(BLK_FIRST_TICKS);
      FPET_OP_SEG: op_ticks = CNT_W'(SEG_TICKS);
      default: op_ticks = CNT_W'(MASS_TICKS);
    endcase
  endfunction

  // Decode helpers
  wire cnt_last = tick && (cnt_ff == CNT_W'(1));
  wire accept = (state_ff == FPET_IDLE) && req.start;
  wire is_prog = (op_ff == FPET_OP_WORD) || (op_ff == FPET_OP_BLOCK);

  // Next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    nxt_done = 1'b0;
    nxt_item = 1'b0;
    case (state_ff)
      FPET_IDLE: begin
        // New request only while idle
        if (accept) begin
          nxt_state = FPET_RUN;
          nxt_op = req.op;
          nxt_cnt = op_ticks(req.op);
        end
      end
      FPET_RUN: begin
        if (tick) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
        if (cnt_last) begin
          if (op_ff == FPET_OP_BLOCK) begin
            nxt_item = 1'b1;
            nxt_state = FPET_BWAIT;
          end else begin
            nxt_done = 1'b1;
            nxt_state = FPET_IDLE;
          end
        end
      end
      FPET_BWAIT: begin
        // Host supplies next item or ends the block
        if (blk_last) begin
          nxt_state = FPET_BEND;
          nxt_cnt = CNT_W'(BLK_END_TICKS);
        end else if (blk_next) begin
          nxt_state = FPET_RUN;
          nxt_cnt = CNT_W'(BLK_NEXT_TICKS);
        end
      end
      FPET_BEND: begin
        if (tick) begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
        if (cnt_last) begin
          nxt_done = 1'b1;
          nxt_state = FPET_IDLE;
        end
      end
      default: begin
        nxt_state = FPET_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= FPET_IDLE;
      cnt_ff <= '0;
      op_ff <= FPET_OP_WORD;
      done_ff <= 1'b0;
      item_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      done_ff <= nxt_done;
      item_ff <= nxt_item;
    end
  end

  // Outputs
  wire busy = (state_ff != FPET_IDLE);
  assign stat = '{busy: busy, done: done_ff, item_pulse: item_ff};
  assign array_pgm_en = (state_ff == FPET_RUN) && is_prog;
  assign array_erase_en = (state_ff == FPET_RUN) && !is_prog;

  // Helper: ticks seen in current run phase, cleared between phases
  logic [CNT_W-1:0] ticks_seen_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ticks_seen_ff <= '0;
    end else if (state_ff != FPET_RUN && state_ff != FPET_BEND) begin
      ticks_seen_ff <= '0;
    end else if (tick) begin
      ticks_seen_ff <= ticks_seen_ff + CNT_W'(1);
    end
  end

  // Word program ends after exactly 30 ticks
  word_len_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FPET_RUN && op_ff == FPET_OP_WORD && cnt_last)
      |-> (ticks_seen_ff == CNT_W'(WORD_TICKS - 1)))
    else $error("word program length wrong");

  // First block item loads 25
  sequence blk_start_s;
    accept && req.op == FPET_OP_BLOCK;
  endsequence
  blk_first_a: assert property (@(posedge clk) disable iff (!nrst)
    blk_start_s |=> (cnt_ff == CNT_W'(BLK_FIRST_TICKS)))
    else $error("block first item count wrong");

  // Following item loads 18
  blk_next_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FPET_BWAIT && blk_next && !blk_last)
      |=> (state_ff == FPET_RUN && cnt_ff == CNT_W'(BLK_NEXT_TICKS)))
    else $error("block next item count wrong");

  // End wait loads 6 then completes
  blk_end_a: assert property (@(posedge clk) disable iff (!nrst)
    (state_ff == FPET_BWAIT && blk_last)
      |=> (state_ff == FPET_BEND && cnt_ff == CNT_W'(BLK_END_TICKS)))
    else $error("block end wait wrong");

  // Erase counts loaded
  seg_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (accept && req.op == FPET_OP_SEG) |=> (cnt_ff == CNT_W'(SEG_TICKS)))
    else $error("segment erase count wrong");
  mass_load_a: assert property (@(posedge clk) disable iff (!nrst)
    (accept && req.op == FPET_OP_MASS) |=> (cnt_ff == CNT_W'(MASS_TICKS)))
    else $error("mass erase count wrong");

  // Busy holds and op is frozen while busy
  busy_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (busy && req.start) |=> $stable(op_ff))
    else $error("request taken while busy");
  done_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    done_ff |-> (!busy && $past(busy)))
    else $error("done without busy end");
  busy_start_a: assert property (@(posedge clk) disable iff (!nrst)
    accept |=> busy)
    else $error("busy missing after start");

  // Last tick of a block item
  sequence blk_item_end_s;
    state_ff == FPET_RUN && op_ff == FPET_OP_BLOCK && cnt_last;
  endsequence
  // Block item runs 25 or 18 ticks, then pauses for the host
  blk_len_a: assert property (@(posedge clk) disable iff (!nrst)
    blk_item_end_s |-> (ticks_seen_ff == CNT_W'(BLK_FIRST_TICKS - 1)
      || ticks_seen_ff == CNT_W'(BLK_NEXT_TICKS - 1)))
    else $error("block item length wrong");
  blk_pause_a: assert property (@(posedge clk) disable iff (!nrst)
    blk_item_end_s |=> (state_ff == FPET_BWAIT && item_ff))
    else $error("block item did not pause");

  // Last tick of the end wait
  sequence blk_end_done_s;
    state_ff == FPET_BEND && cnt_last;
  endsequence
  // End wait runs 6 ticks, then the block completes
  bend_len_a: assert property (@(posedge clk) disable iff (!nrst)
    blk_end_done_s |-> (ticks_seen_ff == CNT_W'(BLK_END_TICKS - 1)))
    else $error("block end wait length wrong");
  bend_done_a: assert property (@(posedge clk) disable iff (!nrst)
    blk_end_done_s |=> (state_ff == FPET_IDLE && done_ff))
    else $error("block end did not complete");

  // Last tick of an erase
  sequence erase_end_s;
    state_ff == FPET_RUN && !is_prog && cnt_last;
  endsequence
  // Erase runs its full SEG_TICKS or MASS_TICKS parameter count
  erase_len_a: assert property (@(posedge clk) disable iff (!nrst)
    erase_end_s |-> (ticks_seen_ff == ((op_ff == FPET_OP_SEG) ? CNT_W'(SEG_TICKS - 1)
      : CNT_W'(MASS_TICKS - 1))))
    else $error("erase length wrong");

endmodule

// [bench/fpet_array_model.sv]
// Flash array stand-in that tallies program ticks
`timescale 1ns/100ps
module fpet_array_model (
  // Clock, reset, timebase
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  // Enables from the sequencer
  input wire logic pgm_en,
  input wire logic erase_en,
  // Tallies for the bench
  output logic [15:0] pgm_ticks_ff,
  output logic [15:0] erase_ticks_ff,
  output logic clash_ff
);
  // Cumulative program time and enable clash
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pgm_ticks_ff <= 16'h0000;
      erase_ticks_ff <= 16'h0000;
      clash_ff <= 1'b0;
    end else begin
      if (pgm_en && tick) pgm_ticks_ff <= pgm_ticks_ff + 16'h0001;
      if (erase_en && tick) erase_ticks_ff <= erase_ticks_ff + 16'h0001;
      if (pgm_en && erase_en) clash_ff <= 1'b1;
    end
  end
endmodule

// [bench/testbench.sv]
// Self-checking bench for the program/erase timing sequencer
`timescale 1ns/100ps
module testbench;
  import fpet_pkg::*;
  logic clk, nrst, tick, blk_next, blk_last, pgm_en, erase_en, clash;
  fpet_req_s req;
  fpet_stat_s stat;
  logic [15:0] pgm_ticks, erase_ticks;
  logic [31:0] ticks;
  logic [31:0] exp_pgm = 32'h0000_0000;
  // Short erase counts, and the software-side time limits
  localparam int SEG_T = 10, MASS_T = 20;
  localparam int CUMULATIVE_PROGRAM_LIMIT_MS = 10, CUMULATIVE_BULK_ERASE_MIN_MS = 20;
  // Program limit in ticks at the slowest timebase
  localparam int PGM_LIMIT_TICKS = TIMEBASE_FREQ_MIN_KHZ * CUMULATIVE_PROGRAM_LIMIT_MS;
  localparam longint BULK_MIN_NS = longint'(CUMULATIVE_BULK_ERASE_MIN_MS) * 1000000;
  int n_mismatch = 0, n_checks = 0, seed = 32'h1fb9d506, div = 100, phase = 0, cyc = 0;
  // Short erase counts
  fpet_seq #(.MASS_TICKS(MASS_T), .SEG_TICKS(SEG_T)) dut (.clk(clk), .nrst(nrst), .tick(tick),
    .req(req), .blk_next(blk_next), .blk_last(blk_last), .stat(stat),
    .array_pgm_en(pgm_en), .array_erase_en(erase_en));
  fpet_array_model array_u (.clk(clk), .nrst(nrst), .tick(tick), .pgm_en(pgm_en),
    .erase_en(erase_en), .pgm_ticks_ff(pgm_ticks), .erase_ticks_ff(erase_ticks),
    .clash_ff(clash));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Timebase pulse every div clocks, 85..155 keeps it in range
  always @(negedge clk) begin
    phase = (phase + 1) % div;
    tick <= (phase == 0);
  end
  // Tick tally and hang guard
  always @(posedge clk) begin
    if (tick && stat.busy) ticks = ticks + 1;
    if (++cyc == 95000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  function automatic logic [31:0] ticks_for(fpet_op_e op, int seg);
    case (op)
      FPET_OP_WORD: return WORD_TICKS;
      FPET_OP_SEG: return SEG_T;
      FPET_OP_MASS: return MASS_T;
      default: return (seg == 0) ? BLK_FIRST_TICKS : BLK_NEXT_TICKS;
    endcase
  endfunction
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  // One operation, with an ignored start while busy
  task automatic run_op(fpet_op_e op, int items);
    int seg;
    seg = 0;
    ticks = 0;
    req <= '{1'b1, op};
    repeat (3) @(negedge clk);
    req <= '{1'b1, fpet_op_e'(~op)};
    check("busy", 32'(stat.busy), 1);
    check("pgm_en", 32'(pgm_en), 32'(op <= FPET_OP_BLOCK));
    check("erase_en", 32'(erase_en), 32'(op >= FPET_OP_SEG));
    @(negedge clk);
    req.start <= 1'b0;
    while (stat.done !== 1'b1) begin
      @(negedge clk);
      if (stat.item_pulse === 1'b1) begin
        check("item ticks", ticks, ticks_for(op, seg));
        seg++;
        ticks = 0;
        blk_next <= 1'b1;
        blk_last <= (seg == items);
        @(negedge clk);
        blk_next <= 1'b0;
        blk_last <= 1'b0;
      end
    end
    if (op == FPET_OP_BLOCK) check("end ticks", ticks, BLK_END_TICKS);
    else check("op ticks", ticks, ticks_for(op, 0));
    check("busy at done", 32'(stat.busy), 0);
    // Program time the flash should have seen
    if (op == FPET_OP_WORD) exp_pgm += WORD_TICKS;
    if (op == FPET_OP_BLOCK) exp_pgm += BLK_FIRST_TICKS + BLK_NEXT_TICKS * (items - 1);
    $display("op %0d with %0d items done", op, items);
  endtask
  // Repeat mass erase until its full-length time reaches the minimum
  task automatic bulk_erase;
    longint acc_ns;
    logic [15:0] base;
    acc_ns = 0;
    for (int n = 0; n < 4 && acc_ns < BULK_MIN_NS; n++) begin
      base = erase_ticks;
      run_op(FPET_OP_MASS, 1);
      acc_ns += longint'(erase_ticks - base) * div * 25 * MASS_ERASE_TICKS / MASS_T;
    end
    check("bulk erase time", 32'(acc_ns >= BULK_MIN_NS), 1);
    $display("bulk erase done");
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    nrst = 1'b0;
    tick = 1'b0;
    blk_next = 1'b0;
    blk_last = 1'b0;
    req = '0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    // Reset in mid-operation returns everything to idle
    req <= '{1'b1, FPET_OP_WORD};
    repeat (40) @(negedge clk);
    check("pgm_en before reset", 32'(pgm_en), 1);
    nrst = 1'b0;
    req <= '0;
    @(negedge clk);
    check("busy in reset", 32'(stat.busy), 0);
    check("pgm_en in reset", 32'(pgm_en), 0);
    nrst = 1'b1;
    $display("mid-run reset done");
    run_op(FPET_OP_BLOCK, 1);
    for (int o = 0; o < 4; o++) run_op(fpet_op_e'(o), 3);
    for (int i = 0; i < 4; i++) begin
      div = 85 + (($random(seed) & 32'h7FFF) % 71);
      run_op(fpet_op_e'($random(seed) & 3), 1 + ($random(seed) & 1));
    end
    bulk_erase;
    check("program tally", 32'(pgm_ticks), exp_pgm);
    check("tally in limit", 32'(pgm_ticks <= PGM_LIMIT_TICKS), 1);
    check("enable clash", 32'(clash), 0);
    end_of_test;
  end
endmodule
